// File: dv/dds_serial_config_registers_tb_top.sv
// Purpose: Self-checking bench of the serial configuration bank.
// Assumes: The host model paces the serial clock well below i_mclk.
// Notes: Mode bits are rewritten with care, since they steer the device port.
`timescale 1ns/1ps
module dds_serial_config_registers_tb_top;
  import dds_cfg_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic sclk, sel_n, resync, sdio, dev_sdio, oe, serial_data_out, bypass;
  logic [4:0] factor;
  logic [31:0] rd;
  cfg_s cfg;
  int num_errors = 0;
  int total_checks = 0;
  logic [4:0] a [7] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h1f};
  int n [7] = '{32, 24, 16, 8, 32, 16, 8};
  logic [31:0] w [7] = '{32'hffff_fcff, 32'hff_ffff, 32'hffff, 32'hff,
                         32'hffff_ffff, 32'hffff, 32'hff};
  logic [31:0] m [7] = '{32'h07c0_37ba, 32'h00_0eff, 32'hffff, 32'hff,
                         32'hffff_ffff, 32'h3fff, 32'h00};
  logic [4:0] codes [4] = '{5'h03, 5'h04, 5'h14, 5'h15};
  `define CHK(x, y) begin total_checks++; if ((x) !== (y)) begin \
    num_errors++; $display("BAD t=%0t got=%0h exp=%0h", $time, x, y); \
    end end
  initial begin
    forever #4 i_mclk = ~i_mclk;
  end
  dds_serial_config_registers i_dut (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_sclk(sclk), .i_port_select_n(sel_n), .i_port_resync(resync),
    .i_sdio(sdio), .o_sdio(dev_sdio), .o_sdio_oe(oe),
    .o_serial_data_out(serial_data_out), .o_cfg(cfg), .o_ref_mult_bypass(bypass),
    .o_ref_mult_factor(factor));
  serial_host_model i_host (.i_mclk(i_mclk), .i_sdio_dev(dev_sdio),
    .i_sdio_oe(oe), .i_serial_data_out(serial_data_out), .o_sclk(sclk),
    .o_port_select_n(sel_n), .o_port_resync(resync), .o_sdio(sdio));
  task automatic wr(input logic [4:0] ad, input logic [31:0] d, input int k);
    i_host.xfer({3'h0, ad}, d, k, 1'b0, rd);
  endtask
  task automatic rr(input logic [4:0] ad, input int k);
    i_host.xfer({3'h4, ad}, 32'h0, k, 1'b0, rd);
  endtask
  task automatic end_sim;
    $display("Checks %0d, errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge i_mclk);
    num_errors++;
    end_sim;
  end
  initial begin
    repeat (2) @(posedge i_mclk);
    #1 i_rst = 1'b0;
    i_host.gap(2);
    `CHK(cfg, cfg_s'(0))
    `CHK(bypass, 1'b1)
    for (int k = 0; k < 7; k++) begin
      wr(a[k], w[k], n[k]);
      rr(a[k], n[k]);
      `CHK(rd, w[k] & m[k])
    end
    `CHK(cfg.ramp_rate, 8'hff)
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_CTL_TWO, {19'h0, codes[k], 3'h0}, 24);
      `CHK(bypass, (k == 0 || k == 3))
      `CHK(factor, (k == 0 || k == 3) ? 5'h00 : codes[k])
    end
    wr(ADDR_RAMP_RATE, 32'h5a, 8);
    wr(ADDR_RAMP_RATE, 32'ha5, 4);
    i_host.xfer(8'h03, 32'hc3, 4, 1'b1, rd);
    rr(ADDR_RAMP_RATE, 8);
    `CHK(rd, 32'h5a)
    wr(ADDR_CTL_ONE, 32'h100, 32);
    i_host.lsb_first = 1'b1;
    wr(ADDR_RAMP_RATE, 32'h1e, 8);
    `CHK(cfg.ramp_rate, 8'h1e)
    rr(ADDR_RAMP_RATE, 8);
    `CHK(rd, 32'h1e)
    wr(ADDR_CTL_ONE, 32'h300, 32);
    i_host.three_wire = 1'b1;
    rr(ADDR_RAMP_RATE, 8);
    `CHK(rd, 32'h1e)
    wr(ADDR_CTL_ONE, 32'h0, 32);
    i_host.lsb_first = 1'b0;
    i_host.three_wire = 1'b0;
    rr(ADDR_RAMP_RATE, 8);
    `CHK(rd, 32'h1e)
    `CHK(serial_data_out, 1'b0)
    end_sim;
  end
endmodule

// File: dv/serial_host_model.sv
// Purpose: Host serial master that drives the configuration port.
// Assumes: Each serial clock level lasts three system clock cycles.
// Notes: A released host shows the inverse of its last bit on the pin.
`timescale 1ns/1ps
module serial_host_model (
  input wire logic i_mclk,
  input wire logic i_sdio_dev,
  input wire logic i_sdio_oe,
  input wire logic i_serial_data_out,
  output logic o_sclk,
  output logic o_port_select_n,
  output logic o_port_resync,
  output logic o_sdio
);
  logic drv_q = 1'b1;
  logic last_q = 1'b0;
  logic lsb_first = 1'b0;
  logic three_wire = 1'b0;
  // The shared pin takes the device level while it drives.
  assign o_sdio = i_sdio_oe ? i_sdio_dev : (drv_q ? last_q : ~last_q);
  initial begin
    o_sclk = 1'b0;
    o_port_select_n = 1'b1;
    o_port_resync = 1'b0;
  end
  task automatic gap(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task automatic bit_cyc(input logic b, output logic r);
    o_sclk = 1'b0;
    last_q = b;
    gap(3);
    o_sclk = 1'b1;
    r = three_wire ? i_serial_data_out : o_sdio;
    gap(3);
  endtask
  task automatic xfer(input logic [7:0] ins, input logic [31:0] wd,
                      input int n, input logic rs, output logic [31:0] rd);
    int i;
    logic r;
    rd = '0;
    o_port_select_n = 1'b0;
    for (i = 0; i < 8; i++) begin
      bit_cyc(lsb_first ? ins[i] : ins[7-i], r);
    end
    drv_q = ~ins[7] | three_wire;
    for (i = 0; i < n; i++) begin
      bit_cyc(lsb_first ? wd[i] : wd[n-1-i], r);
      if (lsb_first) rd[i] = r;
      else rd[n-1-i] = r;
    end
    o_sclk = 1'b0;
    gap(3);
    o_port_resync = rs;
    gap(3);
    o_port_resync = 1'b0;
    // A resync pulse leaves the port selected, so only the resync ends it.
    o_port_select_n = ~rs;
    drv_q = 1'b1;
    gap(3);
  endtask
endmodule

// File: logic/dds_cfg_pkg.sv
// Purpose: Shared constants and types of the serial configuration bank.
// Assumes: Register widths and addresses follow the serial register map.
// Notes: The instruction byte layout here is a local convention.
package dds_cfg_pkg;

  localparam logic [4:0] ADDR_CTL_ONE = 5'h00;
  localparam logic [4:0] ADDR_CTL_TWO = 5'h01;
  localparam logic [4:0] ADDR_AMP_SCALE = 5'h02;
  localparam logic [4:0] ADDR_RAMP_RATE = 5'h03;
  localparam logic [4:0] ADDR_FREQ_TUNE = 5'h04;
  localparam logic [4:0] ADDR_PHASE_OFS = 5'h05;

  localparam int W_CTL_ONE = 32;
  localparam int W_CTL_TWO = 24;
  localparam int W_AMP_SCALE = 16;
  localparam int W_RAMP_RATE = 8;
  localparam int W_FREQ_TUNE = 32;
  localparam int W_PHASE_OFS = 16;

  localparam logic [5:0] LEN_CTL_ONE = 6'h20;
  localparam logic [5:0] LEN_CTL_TWO = 6'h18;
  localparam logic [5:0] LEN_AMP_SCALE = 6'h10;
  localparam logic [5:0] LEN_RAMP_RATE = 6'h08;
  localparam logic [5:0] LEN_FREQ_TUNE = 6'h20;
  localparam logic [5:0] LEN_PHASE_OFS = 6'h10;
  localparam logic [5:0] LEN_INSTR = 6'h08;
  localparam logic [5:0] LEN_UNMAPPED = 6'h08;

  // Bits that hold a function; all others are unused and read as zero.
  localparam logic [31:0] MASK_CTL_ONE = 32'h07c0_37ba;
  localparam logic [23:0] MASK_CTL_TWO = 24'h00_0eff;
  localparam logic [15:0] MASK_AMP_SCALE = 16'hffff;
  localparam logic [7:0] MASK_RAMP_RATE = 8'hff;
  localparam logic [31:0] MASK_FREQ_TUNE = 32'hffff_ffff;
  localparam logic [15:0] MASK_PHASE_OFS = 16'h3fff;

  localparam logic [31:0] RST_CTL_ONE = 32'h0000_0000;
  localparam logic [23:0] RST_CTL_TWO = 24'h00_0000;
  localparam logic [15:0] RST_AMP_SCALE = 16'h0000;
  localparam logic [7:0] RST_RAMP_RATE = 8'h00;
  localparam logic [31:0] RST_FREQ_TUNE = 32'h0000_0000;
  localparam logic [15:0] RST_PHASE_OFS = 16'h0000;

  localparam int INSTR_RD_BIT = 7;
  localparam int INSTR_ADDR_MSB = 4;
  localparam int LSB_FIRST_BIT = 8;
  localparam int INPUT_ONLY_BIT = 9;
  localparam int REF_MULT_MSB = 7;
  localparam int REF_MULT_LSB = 3;
  localparam logic [4:0] REF_MULT_MIN = 5'h04;
  localparam logic [4:0] REF_MULT_MAX = 5'h14;

  typedef enum logic [1:0] {
    ST_INSTR = 2'b00,
    ST_WRITE = 2'b01,
    ST_READ = 2'b10
  } port_state_e;

  typedef struct packed {
    logic [W_CTL_ONE-1:0] ctl_one;
    logic [W_CTL_TWO-1:0] ctl_two;
    logic [W_AMP_SCALE-1:0] amp_scale;
    logic [W_RAMP_RATE-1:0] ramp_rate;
    logic [W_FREQ_TUNE-1:0] freq_tune;
    logic [W_PHASE_OFS-1:0] phase_ofs;
  } cfg_s;

  function automatic logic [5:0] reg_len(input logic [4:0] addr);
    case (addr)
      ADDR_CTL_ONE: reg_len = LEN_CTL_ONE;
      ADDR_CTL_TWO: reg_len = LEN_CTL_TWO;
      ADDR_AMP_SCALE: reg_len = LEN_AMP_SCALE;
      ADDR_RAMP_RATE: reg_len = LEN_RAMP_RATE;
      ADDR_FREQ_TUNE: reg_len = LEN_FREQ_TUNE;
      ADDR_PHASE_OFS: reg_len = LEN_PHASE_OFS;
      default: reg_len = LEN_UNMAPPED;
    endcase
  endfunction

endpackage

// File: logic/dds_serial_config_registers.sv
// Purpose: Serial-port configuration register bank of a frequency
//   synthesizer, with the port modes steered by its own control bits.
// Assumes: Serial clock idles low and all pins are synchronous to i_mclk;
//   the serial clock runs at most at a quarter of i_mclk.
// Notes: Data is taken on serial clock rise and driven after its fall.
// Overview of operation
// - Every configuration register can be written and read back serially.
// - Transfers run MSB first or LSB first as both ends agree.
// - The port works with one shared data pin or with separate in and out.
// - Port select and resync are optional and may both be tied low.
// - Multiplier codes 0x00-0x03 bypass it, 0x04-0x14 multiply by 4-20.
// - The ramp rate register is one 8-bit field at 0x03 reset to zero.
// - The bit-order bit set selects LSB first, clear selects MSB first.
// - The input-only bit set gives 3-wire mode, clear keeps 2-wire mode.
// - The multiplier field sits in bits 7 to 3 of control register two.
`timescale 1ns/1ps
module dds_serial_config_registers
  import dds_cfg_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_sclk,
  input wire logic i_port_select_n,
  input wire logic i_port_resync,
  input wire logic i_sdio,
  output logic o_sdio,
  output logic o_sdio_oe,
  output logic o_serial_data_out,
  output cfg_s o_cfg,
  output logic o_ref_mult_bypass,
  output logic [4:0] o_ref_mult_factor
);

  logic sclk_q;
  port_state_e st_q;
  logic [5:0] cnt_q;
  logic [4:0] addr_q;
  logic [31:0] accum_q;
  logic [31:0] rd_q;
  logic sdio_q;
  logic oe_q;
  logic sdo_q;
  logic bypass_q;
  logic [4:0] factor_q;
  // Each register drives its own word; the struct is packed from them once.
  logic [W_CTL_ONE-1:0] ctl_one_q;
  logic [W_CTL_TWO-1:0] ctl_two_q;
  logic [W_AMP_SCALE-1:0] amp_scale_q;
  logic [W_RAMP_RATE-1:0] ramp_rate_q;
  logic [W_FREQ_TUNE-1:0] freq_tune_q;
  logic [W_PHASE_OFS-1:0] phase_ofs_q;

  // Tying select low and resync low leaves a free-running port.
  wire abort = i_port_select_n | i_port_resync;
  wire rise = i_sclk & ~sclk_q;
  wire fall = ~i_sclk & sclk_q;
  wire lsb_first = o_cfg.ctl_one[LSB_FIRST_BIT];
  wire input_only = o_cfg.ctl_one[INPUT_ONLY_BIT];

  wire [5:0] len = (st_q == ST_INSTR) ? LEN_INSTR : reg_len(addr_q);
  wire [5:0] msb_pos = len - 6'h01 - cnt_q;
  // Bit position of the current serial bit within the word.
  wire [4:0] pos = lsb_first ? cnt_q[4:0] : msb_pos[4:0];
  wire [31:0] bit_mask = 32'h0000_0001 << pos;
  wire [31:0] accum_d = i_sdio ? (accum_q | bit_mask)
                               : (accum_q & ~bit_mask);
  wire last = (cnt_q == len - 6'h01);
  wire [4:0] instr_addr = accum_d[INSTR_ADDR_MSB:0];
  wire instr_rd = accum_d[INSTR_RD_BIT];
  wire wr_en = rise & ~abort & (st_q == ST_WRITE) & last;

  wire wr_ctl_one = wr_en & (addr_q == ADDR_CTL_ONE);
  wire wr_ctl_two = wr_en & (addr_q == ADDR_CTL_TWO);
  wire wr_amp_scale = wr_en & (addr_q == ADDR_AMP_SCALE);
  wire wr_ramp_rate = wr_en & (addr_q == ADDR_RAMP_RATE);
  wire wr_freq_tune = wr_en & (addr_q == ADDR_FREQ_TUNE);
  wire wr_phase_ofs = wr_en & (addr_q == ADDR_PHASE_OFS);

  // Unmapped addresses read as zero, so a stray read is harmless.
  wire [31:0] rd_word =
    (instr_addr == ADDR_CTL_ONE) ? o_cfg.ctl_one :
    (instr_addr == ADDR_CTL_TWO) ? {8'h00, o_cfg.ctl_two} :
    (instr_addr == ADDR_AMP_SCALE) ? {16'h0000, o_cfg.amp_scale} :
    (instr_addr == ADDR_RAMP_RATE) ? {24'h00_0000, o_cfg.ramp_rate} :
    (instr_addr == ADDR_FREQ_TUNE) ? o_cfg.freq_tune :
    (instr_addr == ADDR_PHASE_OFS) ? {16'h0000, o_cfg.phase_ofs} :
    32'h0000_0000;

  wire [4:0] mult = o_cfg.ctl_two[REF_MULT_MSB:REF_MULT_LSB];
  wire bypass_d = (mult < REF_MULT_MIN) | (mult > REF_MULT_MAX);
  wire [4:0] factor_d = bypass_d ? 5'h00 : mult;
  wire rd_bit = rd_q[pos];

  masked_reg #(.WIDTH(W_CTL_ONE), .MASK(MASK_CTL_ONE),
    .RESET(RST_CTL_ONE)) u_ctl_one (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_wr(wr_ctl_one), .i_data(accum_d[W_CTL_ONE-1:0]),
    .o_q(ctl_one_q));
  masked_reg #(.WIDTH(W_CTL_TWO), .MASK(MASK_CTL_TWO),
    .RESET(RST_CTL_TWO)) u_ctl_two (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_wr(wr_ctl_two), .i_data(accum_d[W_CTL_TWO-1:0]),
    .o_q(ctl_two_q));
  masked_reg #(.WIDTH(W_AMP_SCALE), .MASK(MASK_AMP_SCALE),
    .RESET(RST_AMP_SCALE)) u_amp_scale (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_wr(wr_amp_scale), .i_data(accum_d[W_AMP_SCALE-1:0]),
    .o_q(amp_scale_q));
  masked_reg #(.WIDTH(W_RAMP_RATE), .MASK(MASK_RAMP_RATE),
    .RESET(RST_RAMP_RATE)) u_ramp_rate (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_wr(wr_ramp_rate), .i_data(accum_d[W_RAMP_RATE-1:0]),
    .o_q(ramp_rate_q));
  masked_reg #(.WIDTH(W_FREQ_TUNE), .MASK(MASK_FREQ_TUNE),
    .RESET(RST_FREQ_TUNE)) u_freq_tune (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_wr(wr_freq_tune), .i_data(accum_d[W_FREQ_TUNE-1:0]),
    .o_q(freq_tune_q));
  masked_reg #(.WIDTH(W_PHASE_OFS), .MASK(MASK_PHASE_OFS),
    .RESET(RST_PHASE_OFS)) u_phase_ofs (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_wr(wr_phase_ofs), .i_data(accum_d[W_PHASE_OFS-1:0]),
    .o_q(phase_ofs_q));

  assign o_cfg = {ctl_one_q, ctl_two_q, amp_scale_q, ramp_rate_q,
    freq_tune_q, phase_ofs_q};

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      sclk_q <= 1'b0;
      bypass_q <= 1'b1;
      factor_q <= 5'h00;
    end else begin
      sclk_q <= i_sclk;
      bypass_q <= bypass_d;
      factor_q <= factor_d;
    end
  end

  // Sequencer: an instruction byte, then one register's worth of data.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      st_q <= ST_INSTR;
      cnt_q <= 6'h00;
      addr_q <= 5'h00;
      accum_q <= 32'h0000_0000;
      rd_q <= 32'h0000_0000;
    end else if (abort) begin
      st_q <= ST_INSTR;
      cnt_q <= 6'h00;
      accum_q <= 32'h0000_0000;
    end else if (rise) begin
      if (last) begin
        cnt_q <= 6'h00;
        accum_q <= 32'h0000_0000;
        case (st_q)
          ST_INSTR: begin
            addr_q <= instr_addr;
            rd_q <= rd_word;
            st_q <= instr_rd ? ST_READ : ST_WRITE;
          end
          default: begin
            st_q <= ST_INSTR;
          end
        endcase
      end else begin
        cnt_q <= cnt_q + 6'h01;
        accum_q <= accum_d;
      end
    end
  end

  // Read data leaves on the shared pin or on the separate output pin.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      sdio_q <= 1'b0;
      oe_q <= 1'b0;
      sdo_q <= 1'b0;
    end else if (abort || (rise && last && st_q == ST_READ)) begin
      oe_q <= 1'b0;
      sdo_q <= 1'b0;
    end else if (fall && st_q == ST_READ) begin
      sdio_q <= rd_bit;
      oe_q <= ~input_only;
      sdo_q <= input_only & rd_bit;
    end
  end

  assign o_sdio = sdio_q;
  assign o_sdio_oe = oe_q;
  assign o_serial_data_out = sdo_q;
  assign o_ref_mult_bypass = bypass_q;
  assign o_ref_mult_factor = factor_q;

  ramp_write_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    wr_ramp_rate |=> o_cfg.ramp_rate == $past(accum_d[7:0]))
    else $error("ramp rate write not stored");
  ramp_reset_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    $past(i_rst) |-> o_cfg.ramp_rate == RST_RAMP_RATE)
    else $error("ramp rate not zero after reset");
  unused_zero_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    ((o_cfg.ctl_one & ~MASK_CTL_ONE) == '0) &&
    ((o_cfg.ctl_two & ~MASK_CTL_TWO) == '0))
    else $error("unused control bit holds a one");
  mult_map_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    ##1 o_ref_mult_bypass ==
    ($past(mult) < REF_MULT_MIN || $past(mult) > REF_MULT_MAX))
    else $error("multiplier bypass decode wrong");
  mult_factor_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    ##1 !o_ref_mult_bypass |-> o_ref_mult_factor == $past(mult))
    else $error("multiplier factor not from bits 7 to 3");
  two_wire_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_sdio_oe |-> !input_only && !o_serial_data_out)
    else $error("data pin driven in input-only mode");
  three_wire_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_serial_data_out |-> input_only && !o_sdio_oe)
    else $error("separate output used in 2-wire mode");
  bit_order_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (fall && !abort && st_q == ST_READ) |=>
    o_sdio == $past(rd_q[lsb_first ? cnt_q[4:0] : msb_pos[4:0]]))
    else $error("read bit order wrong");
  deselect_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    abort |=> st_q == ST_INSTR && cnt_q == 6'h00 && !o_sdio_oe)
    else $error("port not idle after deselect");

endmodule

// File: logic/masked_reg.sv
// Purpose: One configuration register with a mask of implemented bits.
// Assumes: A write is a single-cycle strobe with the whole word.
// Notes: Unused bits are never stored, so they always read as zero.
`timescale 1ns/1ps
module masked_reg #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] MASK = '1,
  parameter logic [WIDTH-1:0] RESET = '0
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_wr,
  input wire logic [WIDTH-1:0] i_data,
  output logic [WIDTH-1:0] o_q
);

  if (WIDTH < 1 || WIDTH > 32) begin : g_bad_width
    $error("masked_reg width must lie between 1 and 32");
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_q <= RESET & MASK;
    end else if (i_wr) begin
      o_q <= i_data & MASK;
    end
  end

endmodule
